// *** core/lsf_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsf_status #(
  parameter longint IDLE_CYC = lsf_pkg::LSF_IDLE_CYC,
  parameter longint ACT_HOLD_CYC = lsf_pkg::LSF_ACT_HOLD_CYC
) (
  input wire logic I_CLK, // 100 MHz clock
  input wire logic I_RSTN, // Async reset, low
  input wire logic [lsf_pkg::LSF_ADDR_W-1:0] I_AVS_ADDRESS, // Byte address
  input wire logic I_AVS_READ, // Read request
  input wire logic I_AVS_WRITE, // Write request
  input wire logic [3:0] I_AVS_BYTEENABLE, // Byte lanes
  input wire logic [lsf_pkg::LSF_DATA_W-1:0] I_AVS_WRITEDATA, // Write data
  output logic [lsf_pkg::LSF_DATA_W-1:0] O_AVS_READDATA, // Read data
  output logic O_AVS_WAITREQUEST, // Wait request
  input wire logic I_LIN_RX, // Bus receive pin
  input wire logic I_SLAVE_MODE, // Engine in slave mode
  input wire logic I_BUS_SLEEP, // Bus in sleep mode
  input wire logic I_BREAK_DET, // Break field pulse
  input wire logic I_FRAME_START, // Frame transfer start
  input wire logic I_FRAME_DONE, // Frame transfer end
  input wire logic I_ID_RX, // Identifier received
  input wire logic I_IRQ_EVT, // Interrupt event
  input wire logic I_ERR_EVT, // Error detected
  input wire logic I_WAKE_TX, // Sending wakeup, level
  input wire logic I_WAKE_RX, // Wakeup received
  output logic O_IRQ, // Interrupt request
  output logic O_STOP_REQ, // Stop pulse to engine
  output logic O_ERR_CLR, // Error clear pulse
  output logic [7:0] O_STATUS // Status flags
);
  import lsf_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Bus slave

  logic ack_r;
  logic [LSF_DATA_W-1:0] rdata_r;
  logic req;
  logic wr_ok;
  logic [7:0] status;
  logic ctrl_hit;
  logic stop_wr;
  logic irq_clr_wr;
  logic err_clr_wr;

  function automatic logic hit(input logic [LSF_ADDR_W-1:0] a, input logic [5:0] idx);
    hit = (a[1:0] == 2'h0) && (a[LSF_ADDR_W-1:2] == idx);
  endfunction

  assign req = I_AVS_READ | I_AVS_WRITE;
  // One wait cycle gives registered read data
  assign O_AVS_WAITREQUEST = req & ~ack_r;
  assign wr_ok = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
  assign ctrl_hit = wr_ok & hit(I_AVS_ADDRESS, LSF_IDX_CTRL);
  assign stop_wr = ctrl_hit & I_AVS_WRITEDATA[LSF_CTRL_STOP];
  assign irq_clr_wr = ctrl_hit & I_AVS_WRITEDATA[LSF_CTRL_IRQ_CLR];
  assign err_clr_wr = ctrl_hit & I_AVS_WRITEDATA[LSF_CTRL_ERR_CLR];
  assign O_AVS_READDATA = rdata_r;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Control reads zero, unmapped reads zero; reading changes no flag
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_r <= 32'h0;
    end else if (I_AVS_READ && !ack_r) begin
      if (hit(I_AVS_ADDRESS, LSF_IDX_STATUS)) begin
        rdata_r <= {24'h0, status};
      end else begin
        rdata_r <= 32'h0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_STOP_REQ <= 1'b0;
      O_ERR_CLR <= 1'b0;
    end else begin
      O_STOP_REQ <= stop_wr;
      O_ERR_CLR <= err_clr_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus pin synchroniser and edge detect

  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_stable_r;
  logic rx_edge;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_stable_r <= 1'b1;
    end else begin
      rx_s1_r <= I_LIN_RX;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_stable_r <= rx_s3_r;
      end
    end
  end

  // A change counts once two stages agree
  assign rx_edge = (rx_s2_r == rx_s3_r) && (rx_s3_r != rx_stable_r);

  ////////////////////////////////////////////////////////////////////
  // Activity and idle timeout

  localparam logic [LSF_CNT_W-1:0] ACT_MAX = LSF_CNT_W'(ACT_HOLD_CYC);
  localparam logic [LSF_CNT_W-1:0] IDLE_MAX = LSF_CNT_W'(IDLE_CYC);

  logic [LSF_CNT_W-1:0] act_cnt_r;
  logic [LSF_CNT_W-1:0] idle_cnt_r;
  logic active_r;
  logic idle_r;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      act_cnt_r <= '0;
      active_r <= 1'b0;
    end else if (rx_edge) begin
      act_cnt_r <= ACT_MAX;
      active_r <= 1'b1;
    end else if (act_cnt_r != '0) begin
      act_cnt_r <= act_cnt_r - 1'b1;
      active_r <= (act_cnt_r != LSF_CNT_W'(1));
    end else begin
      active_r <= 1'b0;
    end
  end

  // Counter saturates so the flag stays until activity returns, the bus sleeps or the engine leaves slave mode
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      idle_cnt_r <= '0;
    end else if (rx_edge || I_BUS_SLEEP || !I_SLAVE_MODE) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != IDLE_MAX) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      idle_r <= 1'b0;
    end else begin
      idle_r <= I_SLAVE_MODE && !I_BUS_SLEEP && !rx_edge &&
                (idle_cnt_r == IDLE_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame, interrupt, error and wakeup flags

  logic in_frame_r;
  logic abort_r;
  logic idreq_r;
  logic irq_r;
  logic err_r;
  logic wake_rx_r;
  logic done_r;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      in_frame_r <= 1'b0;
    end else if (I_FRAME_START) begin
      in_frame_r <= 1'b1;
    end else if (I_FRAME_DONE || stop_wr) begin
      in_frame_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      abort_r <= 1'b0;
    end else if (I_SLAVE_MODE && ((I_BREAK_DET && in_frame_r) || stop_wr)) begin
      abort_r <= 1'b1;
    end else if (I_BREAK_DET && !in_frame_r) begin
      abort_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      idreq_r <= 1'b0;
    end else if (!I_SLAVE_MODE) begin
      idreq_r <= 1'b0;
    end else if (I_ID_RX) begin
      idreq_r <= 1'b1;
    end else if (I_BREAK_DET || I_FRAME_DONE || stop_wr) begin
      idreq_r <= 1'b0;
    end
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_r <= 1'b0;
    end else if (I_IRQ_EVT) begin
      irq_r <= 1'b1;
    end else if (irq_clr_wr) begin
      irq_r <= 1'b0;
    end
  end

  assign O_IRQ = irq_r;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      err_r <= 1'b0;
    end else if (I_ERR_EVT) begin
      err_r <= 1'b1;
    end else if (err_clr_wr) begin
      err_r <= 1'b0;
    end
  end

  // Received wakeup is remembered until the next break
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wake_rx_r <= 1'b0;
    end else if (I_WAKE_RX) begin
      wake_rx_r <= 1'b1;
    end else if (I_BREAK_DET) begin
      wake_rx_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      done_r <= 1'b0;
    end else if (I_FRAME_DONE) begin
      done_r <= 1'b1;
    end else if (I_FRAME_START) begin
      done_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status word

  always_comb begin
    status = LSF_STATUS_RST;
    status[LSF_ST_ACTIVE] = active_r;
    status[LSF_ST_IDLE] = idle_r;
    status[LSF_ST_ABORT] = abort_r;
    status[LSF_ST_IDREQ] = idreq_r;
    status[LSF_ST_IRQ] = irq_r;
    status[LSF_ST_ERR] = err_r;
    status[LSF_ST_WAKE] = I_WAKE_TX | wake_rx_r;
    status[LSF_ST_DONE] = done_r;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_STATUS <= LSF_STATUS_RST;
    end else begin
      O_STATUS <= status;
    end
  end

endmodule
`default_nettype wire

// *** core/lsf_pkg.sv ***
package lsf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] LSF_IDX_CTRL = 6'h08;
  localparam logic [5:0] LSF_IDX_STATUS = 6'h09;
  localparam int LSF_ADDR_W = 8;
  localparam int LSF_DATA_W = 32;
  // Control bit positions (write-one pulses, read as zero)
  localparam int LSF_CTRL_STOP = 7;
  localparam int LSF_CTRL_IRQ_CLR = 3;
  localparam int LSF_CTRL_ERR_CLR = 2;
  // Status bit positions
  localparam int LSF_ST_ACTIVE = 7;
  localparam int LSF_ST_IDLE = 6;
  localparam int LSF_ST_ABORT = 5;
  localparam int LSF_ST_IDREQ = 4;
  localparam int LSF_ST_IRQ = 3;
  localparam int LSF_ST_ERR = 2;
  localparam int LSF_ST_WAKE = 1;
  localparam int LSF_ST_DONE = 0;
  localparam logic [7:0] LSF_STATUS_RST = 8'h00;
  // Timing
  localparam longint LSF_CLK_HZ = 100000000;
  localparam longint LSF_IDLE_S = 4;
  localparam longint LSF_IDLE_CYC = LSF_IDLE_S * LSF_CLK_HZ;
  localparam longint LSF_ACT_HOLD_US = 1000;
  localparam longint LSF_ACT_HOLD_CYC = (LSF_ACT_HOLD_US * LSF_CLK_HZ) / 1000000;
  localparam int LSF_CNT_W = 29;
endpackage

// *** sim/lsf_status_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsf_status_props (
  input wire logic I_CLK, // clock
  input wire logic I_RSTN, // reset
  input wire logic [7:0] I_AVS_ADDRESS, // addr
  input wire logic I_AVS_READ, // read
  input wire logic I_AVS_WRITE, // write
  input wire logic [3:0] I_AVS_BYTEENABLE, // lanes
  input wire logic [31:0] I_AVS_WRITEDATA, // wdata
  input wire logic O_AVS_WAITREQUEST, // wait
  input wire logic I_SLAVE_MODE, // slave
  input wire logic I_FRAME_START, // start
  input wire logic I_FRAME_DONE, // end
  input wire logic I_ID_RX, // id
  input wire logic I_IRQ_EVT, // irq event
  input wire logic I_ERR_EVT, // error event
  input wire logic I_WAKE_TX, // wake send
  input wire logic O_IRQ, // irq
  input wire logic O_STOP_REQ, // stop pulse
  input wire logic O_ERR_CLR, // clear pulse
  input wire logic [7:0] O_STATUS // flags
);
  logic ctl_wr;
  // Only a taken, low-lane write to the control word counts
  assign ctl_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 8'h20
    && I_AVS_BYTEENABLE[0];
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  sequence one_wait;
    O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
  endsequence
  sequence stop_seen;
    O_STOP_REQ ##1 O_STATUS[5];
  endsequence
  ////////////////////////////////////////////////////////////////
  bus_wait_a: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |-> one_wait)
    else $error("bus answer not after one wait");
  irq_set_a: assert property (I_IRQ_EVT |=> O_IRQ)
    else $error("irq not raised");
  irq_copy_a: assert property (O_STATUS[3] == $past(O_IRQ))
    else $error("status irq bit differs");
  irq_keep_a: assert property (O_IRQ && !(ctl_wr && I_AVS_WRITEDATA[3]) |=> O_IRQ)
    else $error("irq dropped without clear");
  irq_clr_a: assert property (ctl_wr && I_AVS_WRITEDATA[3] && !I_IRQ_EVT |=> !O_IRQ)
    else $error("irq not cleared");
  err_set_a: assert property (I_ERR_EVT |-> ##2 O_STATUS[2])
    else $error("error flag not set");
  err_pulse_a: assert property (ctl_wr && I_AVS_WRITEDATA[2] |=> O_ERR_CLR ##1 !O_ERR_CLR)
    else $error("error clear pulse wrong");
  stop_abort_a: assert property (ctl_wr && I_AVS_WRITEDATA[7] && I_SLAVE_MODE |=> stop_seen)
    else $error("stop did not abort");
  id_set_a: assert property (I_ID_RX && I_SLAVE_MODE |-> ##2 O_STATUS[4])
    else $error("id flag not set");
  wake_tx_a: assert property (I_WAKE_TX |=> O_STATUS[1])
    else $error("wake flag not shown");
  done_set_a: assert property (I_FRAME_DONE |-> ##2 O_STATUS[0])
    else $error("done flag not set");
  done_clr_a: assert property (I_FRAME_START && !I_FRAME_DONE |-> ##2 !O_STATUS[0])
    else $error("done flag not cleared");
endmodule
`default_nettype wire

// *** sim/lsf_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsf_bus_model (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset, low
  input wire logic i_run, // frames on bus
  output logic o_rx // bus level
);
  logic [1:0] cnt_r;
  // edges only in frames
  // Pulled-up bus: released line rests high with no edges
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 2'h0;
      o_rx <= 1'b1;
    end else if (i_run) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r[0]) o_rx <= ~o_rx;
    end else begin
      o_rx <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** sim/test_lsf_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_lsf_status;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic run = 1'b0;
  logic slave = 1'b0;
  logic sleep = 1'b0;
  logic wake_tx = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0;
  logic [6:0] ev = 7'h00;
  logic [31:0] q, rdata;
  logic wreq, rx, irq, stop, errclr;
  logic [7:0] status;
  int errors = 0;
  int checks_done = 0;
  localparam int BRK = 0, STA = 1, FIN = 2, IDR = 3, IRQ = 4, ERR = 5, WRX = 6;
  always #5 clk = ~clk;
  lsf_bus_model i_bus (.i_clk(clk), .i_rstn(rstn), .i_run(run), .o_rx(rx));
  // Short counts keep idle and activity windows inside the run
  lsf_status #(.IDLE_CYC(50), .ACT_HOLD_CYC(20)) i_dut (.I_CLK(clk), .I_RSTN(rstn),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(be),
    .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .I_LIN_RX(rx), .I_SLAVE_MODE(slave), .I_BUS_SLEEP(sleep), .I_BREAK_DET(ev[BRK]),
    .I_FRAME_START(ev[STA]), .I_FRAME_DONE(ev[FIN]), .I_ID_RX(ev[IDR]),
    .I_IRQ_EVT(ev[IRQ]), .I_ERR_EVT(ev[ERR]), .I_WAKE_TX(wake_tx), .I_WAKE_RX(ev[WRX]),
    .O_IRQ(irq), .O_STOP_REQ(stop), .O_ERR_CLR(errclr), .O_STATUS(status));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    // A slave that never answers counts as a mismatch and ends the run
    if (wreq !== 1'b0) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, wreq, 1'b0);
      summarize();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e);
    xfer(1'b0, 8'h24, 32'h0);
    chk(q, e);
    // Flags are steady here, so the registered status copy must agree
    chk({24'h0, status}, e);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    ev[n] <= 1'b1;
    @(posedge clk);
    ev[n] <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    st(32'h0);
    xfer(1'b1, 8'h24, 32'hff);
    st(32'h0);
    xfer(1'b0, 8'h30, 32'h0);
    chk(q, 32'h0);
    pulse(IRQ);
    st(32'h08);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, 8'h20, 32'h00);
    st(32'h08);
    xfer(1'b1, 8'h20, 32'h08);
    // The clear lands at the accepting edge; look one edge later
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    st(32'h0);
    pulse(ERR);
    be <= 4'he;
    xfer(1'b1, 8'h20, 32'h04);
    be <= 4'hf;
    st(32'h04);
    xfer(1'b1, 8'h20, 32'h04);
    st(32'h0);
    pulse(STA);
    st(32'h0);
    pulse(FIN);
    st(32'h01);
    pulse(STA);
    st(32'h0);
    pulse(FIN);
    st(32'h01);
    wake_tx <= 1'b1;
    st(32'h03);
    wake_tx <= 1'b0;
    st(32'h01);
    pulse(WRX);
    st(32'h03);
    pulse(BRK);
    st(32'h01);
    // Master mode: identifier and stop must leave the slave-only flags low
    pulse(IDR);
    st(32'h01);
    xfer(1'b1, 8'h20, 32'h80);
    st(32'h01);
    run <= 1'b1;
    repeat (10) @(posedge clk);
    st(32'h81);
    slave <= 1'b1;
    pulse(IDR);
    st(32'h91);
    pulse(STA);
    st(32'h90);
    pulse(BRK);
    st(32'ha0);
    pulse(FIN);
    st(32'ha1);
    pulse(BRK);
    st(32'h81);
    xfer(1'b1, 8'h20, 32'h80);
    st(32'ha1);
    run <= 1'b0;
    repeat (80) @(posedge clk);
    st(32'h61);
    sleep <= 1'b1;
    st(32'h21);
    // Second reset with flags set: all must return to zero
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    st(32'h0);
    summarize();
  end
endmodule
bind lsf_status lsf_status_props i_chk (
  .I_CLK(I_CLK),
  .I_RSTN(I_RSTN),
  .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
  .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_SLAVE_MODE(I_SLAVE_MODE),
  .I_FRAME_START(I_FRAME_START),
  .I_FRAME_DONE(I_FRAME_DONE),
  .I_ID_RX(I_ID_RX),
  .I_IRQ_EVT(I_IRQ_EVT),
  .I_ERR_EVT(I_ERR_EVT),
  .I_WAKE_TX(I_WAKE_TX),
  .O_IRQ(O_IRQ),
  .O_STOP_REQ(O_STOP_REQ),
  .O_ERR_CLR(O_ERR_CLR),
  .O_STATUS(O_STATUS)
);
`default_nettype wire
